// ### ccx_consts.svh
// Constants for the clear and subroutine-jump execution block.
// Assumes inclusion by the package and the design modules only.
`ifndef CCX_CONSTS_SVH
`define CCX_CONSTS_SVH

// ==========================================================================
// Opcode fields of the 14-bit instruction word
`define CCX_CALL_OP        3'h4
`define CCX_CALL_OP_MSB    13
`define CCX_CALL_OP_LSB    11
`define CCX_CLR_FILE_OP    7'h03
`define CCX_CLR_ACC_WORD   14'h0103
`define CCX_CLR_OP_MSB     13
`define CCX_CLR_OP_LSB     7
`define CCX_FADDR_MSB      6
`define CCX_TARGET_MSB     10
// Page latch bits that feed the upper counter bits
`define CCX_LATCH_PAGE_MSB 4
`define CCX_LATCH_PAGE_LSB 3
// Reset values and cycle counts
`define CCX_PC_RESET       13'h0000
`define CCX_CALL_CYCLES    2'h2
`define CCX_ZERO_BYTE      8'h00

`endif

// ### ccx_decode.sv
// Decoder for the subroutine-jump and the two clear instructions.
// Assumes a 14-bit instruction word valid in the cycle it is presented.
`timescale 1ns/100ps
module ccx_decode
    import ccx_pkg::*;
(
    input  wire logic [13:0] instr,
    output ccx_op_type       op
);
    `include "ccx_consts.svh"

    // ======================================================================
    // Opcode match
    always_comb begin
        if (instr[`CCX_CALL_OP_MSB:`CCX_CALL_OP_LSB] == `CCX_CALL_OP) begin
            op = CCX_OP_CALL;
        end else if (instr == `CCX_CLR_ACC_WORD) begin
            op = CCX_OP_CLR_ACC;
        end else if (instr[`CCX_CLR_OP_MSB:`CCX_CLR_OP_LSB] == `CCX_CLR_FILE_OP) begin
            op = CCX_OP_CLR_FILE;
        end else begin
            op = CCX_OP_NONE;
        end
    end
endmodule

// ### ccx_exec.sv
// Execution unit for the subroutine-jump and the two clear instructions.
// Assumes one instruction per sys_clk cycle, the page latch held by the core.
// Assumes the core holds off fetch side effects while busy is high.
//
// Function
// - Subroutine jump first pushes program counter plus one onto stack top.
// - Subroutine jump loads its 11-bit target into counter bits 10..0.
// - On a subroutine jump, counter bits 12..11 come from page latch bits 4..3.
// - Subroutine jump is one word, two cycles, flags untouched.
// - Clear accumulator writes zero to working register, sets zero flag.
`timescale 1ns/100ps
module ccx_exec
    import ccx_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    input  wire logic [7:0]  pc_high_latch,
    input  wire logic        zero_flag_in,
    output logic [12:0]      program_counter,
    output ccx_push_type     stack_push,
    output ccx_fwrite_type   file_write,
    output logic             accum_write,
    output logic [7:0]       accum_data,
    output logic             zero_flag,
    output logic             busy
);
    `include "ccx_consts.svh"

    // ======================================================================
    // State machine
    typedef enum logic [1:0] {
        CCX_ST_RUN   = 2'h1,
        CCX_ST_FLUSH = 2'h2
    } ccx_state_type;

    ccx_op_type     op;
    ccx_state_type  state_r,  state_nxt;
    logic [12:0]    pc_r,     pc_nxt;
    ccx_push_type   push_r,   push_nxt;
    ccx_fwrite_type fwr_r,    fwr_nxt;
    logic           wwr_r,    wwr_nxt;
    logic           zf_r,     zf_nxt;
    logic [1:0]     cyc_r,    cyc_nxt;
    logic           busy_r,   busy_nxt;

    // Opcode decoder
    ccx_decode u_decode (
        .instr (instr),
        .op    (op)
    );

    // ======================================================================
    // Next-state computation
    always_comb begin
        state_nxt = state_r;
        pc_nxt    = pc_r;
        push_nxt  = '0;
        fwr_nxt   = '0;
        wwr_nxt   = 1'b0;
        zf_nxt    = zero_flag_in;
        cyc_nxt   = cyc_r;
        unique case (state_r)
            CCX_ST_RUN: begin
                if (instr_valid) begin
                    pc_nxt = pc_r + 13'h0001;
                    unique case (op)
                        CCX_OP_CALL: begin
                            push_nxt.en   = 1'b1;
                            push_nxt.addr = pc_r + 13'h0001;
                            pc_nxt = {pc_high_latch[`CCX_LATCH_PAGE_MSB:`CCX_LATCH_PAGE_LSB],
                                      instr[`CCX_TARGET_MSB:0]};
                            state_nxt = CCX_ST_FLUSH;
                            cyc_nxt   = 2'h1;
                        end
                        CCX_OP_CLR_FILE: begin
                            fwr_nxt.en   = 1'b1;
                            fwr_nxt.addr = instr[`CCX_FADDR_MSB:0];
                            fwr_nxt.data = `CCX_ZERO_BYTE;
                            zf_nxt       = 1'b1;
                        end
                        CCX_OP_CLR_ACC: begin
                            wwr_nxt = 1'b1;
                            zf_nxt  = 1'b1;
                        end
                        CCX_OP_NONE: begin
                        end
                    endcase
                end
            end
            CCX_ST_FLUSH: begin
                // Second cycle of the jump, fetched word discarded
                cyc_nxt = cyc_r + 2'h1;
                if (cyc_r + 2'h1 >= `CCX_CALL_CYCLES) begin
                    state_nxt = CCX_ST_RUN;
                    cyc_nxt   = 2'h0;
                end
            end
            default: begin
                state_nxt = CCX_ST_RUN;
            end
        endcase
        // Busy follows the state about to be entered
        busy_nxt = (state_nxt == CCX_ST_FLUSH);
    end

    // ======================================================================
    // Registers
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_r <= CCX_ST_RUN;
            pc_r    <= `CCX_PC_RESET;
            push_r  <= '0;
            fwr_r   <= '0;
            wwr_r   <= 1'b0;
            zf_r    <= 1'b0;
            cyc_r   <= 2'h0;
            busy_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
            push_r  <= push_nxt;
            fwr_r   <= fwr_nxt;
            wwr_r   <= wwr_nxt;
            zf_r    <= zf_nxt;
            cyc_r   <= cyc_nxt;
            busy_r  <= busy_nxt;
        end
    end

    // Outputs straight from flip-flops, accum_data tied to a constant zero
    assign program_counter = pc_r;
    assign stack_push      = push_r;
    assign file_write      = fwr_r;
    assign accum_write     = wwr_r;
    assign accum_data      = `CCX_ZERO_BYTE;
    assign zero_flag       = zf_r;
    assign busy            = busy_r;

    // ======================================================================
    // Assertions
    // ======================================================================
    // Subroutine jump: push, target bits and page bits
    a_call_push_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CALL && state_r == CCX_ST_RUN)
        |=> (stack_push.en && stack_push.addr == $past(pc_r) + 13'h0001))
        else $error("jump push address wrong");

    a_push_one_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        stack_push.en |=> !stack_push.en)
        else $error("stack push longer than one cycle");

    a_call_low_pc: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CALL && state_r == CCX_ST_RUN)
        |=> (program_counter[10:0] == $past(instr[10:0])))
        else $error("jump target low bits wrong");

    a_call_page_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CALL && state_r == CCX_ST_RUN)
        |=> (program_counter[12:11] == $past(pc_high_latch[4:3])))
        else $error("jump page bits wrong");

    // ======================================================================
    // Subroutine jump: length, refusal and untouched flags
    a_call_two_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CALL && state_r == CCX_ST_RUN)
        |=> busy ##1 !busy)
        else $error("jump not two cycles");

    a_call_flags_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CALL && state_r == CCX_ST_RUN)
        |=> (zero_flag == $past(zero_flag_in) && !file_write.en && !accum_write))
        else $error("jump altered flags or registers");

    a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (busy && instr_valid)
        |=> (!stack_push.en && !file_write.en && !accum_write
             && program_counter == $past(program_counter)))
        else $error("word taken during jump flush");

    a_flush_flag_kept: assert property (@(posedge sys_clk) disable iff (!rst_b)
        busy |=> (zero_flag == $past(zero_flag_in)))
        else $error("zero flag changed during jump flush");

    // ======================================================================
    // Clear instructions: destination, zero flag and single cycle; idle cycle hold
    a_file_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CLR_FILE && state_r == CCX_ST_RUN)
        |=> (file_write.en && file_write.data == 8'h00 && zero_flag
             && file_write.addr == $past(instr[6:0])))
        else $error("file clear wrong");

    a_file_clear_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CLR_FILE && state_r == CCX_ST_RUN)
        |=> (!accum_write && !stack_push.en))
        else $error("file clear touched another register");

    a_accum_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && op == CCX_OP_CLR_ACC && state_r == CCX_ST_RUN)
        |=> (accum_write && accum_data == 8'h00 && zero_flag && !file_write.en))
        else $error("accumulator clear wrong");

    a_clr_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (instr_valid && (op == CCX_OP_CLR_FILE || op == CCX_OP_CLR_ACC) && state_r == CCX_ST_RUN)
        |=> (!busy && !stack_push.en && program_counter == $past(pc_r) + 13'h0001))
        else $error("clear not single cycle");

    a_idle_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!instr_valid && state_r == CCX_ST_RUN)
        |=> (program_counter == $past(program_counter) && !file_write.en && !accum_write))
        else $error("idle cycle changed state");

    // ======================================================================
    // Main scenarios
    c_call: cover property (@(posedge sys_clk) stack_push.en ##1 busy);
    c_file_clear: cover property (@(posedge sys_clk) file_write.en);
    c_accum_clear: cover property (@(posedge sys_clk) accum_write);
    c_back: cover property (@(posedge sys_clk) file_write.en ##1 accum_write);
    c_refuse: cover property (@(posedge sys_clk) busy && instr_valid);
endmodule

// ### ccx_pkg.sv
// Types for the clear and subroutine-jump execution block.
// Assumes the constants header sits in the same folder.
package ccx_pkg;
    `include "ccx_consts.svh"

    // ======================================================================
    // Decoded instruction classes
    typedef enum logic [3:0] {
        CCX_OP_NONE = 4'h1,
        CCX_OP_CALL = 4'h2,
        CCX_OP_CLR_FILE = 4'h4,
        CCX_OP_CLR_ACC  = 4'h8
    } ccx_op_type;

    // File register write request
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } ccx_fwrite_type;

    // Stack push request
    typedef struct packed {
        logic        en;
        logic [12:0] addr;
    } ccx_push_type;
endpackage

// ### clear_and_call_instr_exec_test.sv
// Testbench for the clear and subroutine-jump execution block.
// Assumes ccx_pkg and ccx_exec are compiled first; drives all inputs itself.
`timescale 1ns/100ps
module clear_and_call_instr_exec_test;
    import ccx_pkg::*;

    // ======================================================================
    // Signals and counters
    logic           sys_clk;
    logic           rst_b;
    logic           instr_valid;
    logic [13:0]    instr;
    logic [7:0]     pc_high_latch;
    logic [7:0]     latch_next;
    logic           zero_flag_in;
    logic [12:0]    program_counter;
    ccx_push_type   stack_push;
    ccx_fwrite_type file_write;
    logic           accum_write;
    logic [7:0]     accum_data;
    logic           zero_flag;
    logic           busy;
    int             n_mismatch;
    int             n_tests;
    int             n_cycles;

    ccx_exec i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
        .pc_high_latch(pc_high_latch), .zero_flag_in(zero_flag_in), .program_counter(program_counter),
        .stack_push(stack_push), .file_write(file_write), .accum_write(accum_write),
        .accum_data(accum_data), .zero_flag(zero_flag), .busy(busy));

    // ======================================================================
    // Clock and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_cycles++;
        if (n_cycles == 2000) begin
            n_mismatch++;
            results();
        end
    end

    // ======================================================================
    // Shared tasks
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One cycle: inputs at falling edge, outputs settled after rising edge
    task automatic step(input logic v, input logic [13:0] w, input logic zin, input logic rb);
        @(negedge sys_clk);
        instr_valid = v;
        instr = w;
        zero_flag_in = zin;
        rst_b = rb;
        pc_high_latch = latch_next;
        @(posedge sys_clk);
        #1;
    endtask
    // Compare every output at once, accumulator data always zero
    task automatic outs(input logic [12:0] pc, input logic [13:0] sp, input logic [15:0] fw,
                        input logic aw, input logic zf, input logic bz, input string m);
        n_tests++;
        if ({program_counter, stack_push, file_write, accum_write, accum_data, zero_flag, busy}
            !== {pc, sp, fw, aw, 8'h00, zf, bz})
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // ======================================================================
    // Scenarios
    task automatic t_clears();
        step(1'b1, 14'h0103, 1'b0, 1'b1);
        outs(13'h0001, 14'h0000, 16'h0000, 1'b1, 1'b1, 1'b0, "accum clear");
        step(1'b1, 14'h01FF, 1'b0, 1'b1);
        outs(13'h0002, 14'h0000, 16'hFF00, 1'b0, 1'b1, 1'b0, "file clear top");
        step(1'b1, 14'h0180, 1'b0, 1'b1);
        outs(13'h0003, 14'h0000, 16'h8000, 1'b0, 1'b1, 1'b0, "file clear zero");
        step(1'b1, 14'h0000, 1'b0, 1'b1);
        outs(13'h0004, 14'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, "other word");
        $display("test clears done");
    endtask
    task automatic t_call_top();
        latch_next = 8'h18;
        step(1'b1, 14'h27FF, 1'b1, 1'b1);
        outs(13'h1FFF, 14'h2005, 16'h0000, 1'b0, 1'b1, 1'b1, "jump top");
        step(1'b1, 14'h0103, 1'b0, 1'b1);
        outs(13'h1FFF, 14'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, "busy refuse");
        $display("test call top done");
    endtask
    task automatic t_call_wrap();
        latch_next = 8'hE7;
        step(1'b1, 14'h2000, 1'b0, 1'b1);
        outs(13'h0000, 14'h2000, 16'h0000, 1'b0, 1'b0, 1'b1, "jump wrap");
        step(1'b0, 14'h0103, 1'b1, 1'b1);
        outs(13'h0000, 14'h0000, 16'h0000, 1'b0, 1'b1, 1'b0, "second cycle");
        step(1'b1, 14'h0103, 1'b0, 1'b1);
        outs(13'h0001, 14'h0000, 16'h0000, 1'b1, 1'b1, 1'b0, "after jump");
        $display("test call wrap done");
    endtask
    task automatic t_mid_reset();
        latch_next = 8'h08;
        step(1'b1, 14'h2123, 1'b0, 1'b1);
        outs(13'h0923, 14'h2002, 16'h0000, 1'b0, 1'b0, 1'b1, "jump page one");
        step(1'b1, 14'h0103, 1'b1, 1'b0);
        outs(13'h0000, 14'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, "reset in jump");
        step(1'b1, 14'h0103, 1'b0, 1'b1);
        outs(13'h0001, 14'h0000, 16'h0000, 1'b1, 1'b1, 1'b0, "clear after release");
        step(1'b1, 14'h0000, 1'b1, 1'b1);
        outs(13'h0002, 14'h0000, 16'h0000, 1'b0, 1'b1, 1'b0, "flag pass through");
        $display("test mid reset done");
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr = 14'h0000;
        pc_high_latch = 8'h00;
        latch_next = 8'h00;
        zero_flag_in = 1'b0;
        n_mismatch = 0;
        n_tests = 0;
        n_cycles = 0;
        repeat (6) step(1'b0, 14'h0000, 1'b0, 1'b0);
        outs(13'h0000, 14'h0000, 16'h0000, 1'b0, 1'b0, 1'b0, "reset state");
        t_clears();
        t_call_top();
        t_call_wrap();
        t_mid_reset();
        results();
    end
endmodule
